// ==== wor_delay_counter.sv ====
// wor_delay_counter: counts a loaded number of tick pulses, then pulses done.
// Assumes tick is a one-cycle pulse on clk.
`timescale 1ns/10ps
module wor_delay_counter #(
   parameter int WIDTH = 13
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic start,
   input wire logic [WIDTH-1:0] length,
   input wire logic tick,
   output logic busy,
   output logic done
);
   logic [WIDTH-1:0] remaining;
   logic [WIDTH-1:0] next_remaining;
   logic lastTick;

   assign busy = (remaining != '0);
   assign lastTick = busy && tick && (remaining == WIDTH'(1));
   assign next_remaining = start ? length : (busy && tick) ? remaining - WIDTH'(1) : remaining;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         remaining <= '0;
         done <= 1'b0;
      end else begin
         remaining <= next_remaining;
         done <= lastTick && !start;
      end
   end
endmodule : wor_delay_counter

// ==== wor_option_register.sv ====
// wor_option_register: write-once system option register with static option outputs,
// stop-mode sequencing and stop-recovery delay.
// Assumes a classic Wishbone master on clk; oscillator and monitor pins are asynchronous.
//
// How it works
// - option register at index 1F takes one software write per reset period
// - every reset returns all options to fixed default values in plain flops
// - slow crystal bit picks slow crystal and low clock-monitor expectation
// - monitor runs in stop only if in-stop bit and power bit both set
// - reset clears the monitor-in-stop bit
// - reset-enable bit passes the monitor reset request, else blocks it
// - monitor power bit powers the voltage monitor
// - watchdog rate bit picks 2^13-2^4 or 2^18-2^4 cycles; reset clears it
// - short recovery bit makes stop exit wait 32 instead of 4096 cycles
// - leaving stop through reset always uses the long recovery delay
// - stop-enable bit allows stop; otherwise stop opcode is illegal
// - watchdog-disable bit turns the watchdog off, else it runs
//
// The Wishbone interface to the registers is this design's own decision.
`timescale 1ns/10ps
module wor_option_register (
   input wire logic clk,
   input wire logic sys_rst,
   // wishbone slave
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic [31:0] wb_dat_i,
   output logic [31:0] wb_dat_o,
   output logic wb_ack_o,
   // pins from outside the clock domain
   input wire logic oscillatorClock,
   input wire logic voltMonitorResetRequest,
   // same-clock events from the processor
   input wire logic stopOpcodeFetch,
   input wire logic stopWakeup,
   input wire logic stopExitByReset,
   // static controls to consuming modules
   output wor_pkg::wor_options_type options,
   output logic clockSlowCrystal,
   output logic clockMonitorExpectLow,
   output logic voltMonitorPowerOn,
   output logic voltMonitorResetOut,
   output logic watchdogEnable,
   output logic [17:0] watchdogTimeout,
   // stop-mode control
   output logic stopAccepted,
   output logic illegalOpcode,
   output logic inStopMode,
   output logic cpuHold,
   output logic recoveryDone
);

   // ---------------------------------------------------------------
   // declarations
   // ---------------------------------------------------------------
   wor_pkg::wor_options_type next_options;
   wor_pkg::wor_options_type writeOptions;
   wor_pkg::wor_power_state_type powerState;
   wor_pkg::wor_power_state_type next_powerState;
   logic locked;
   logic next_locked;
   logic [31:0] next_wbDat;
   logic busRequest;
   logic optionHit;
   logic statusHit;
   logic writeStrobe;
   logic optionWrite;
   logic [31:0] readMux;
   logic [7:0] statusByte;
   logic [7:0] optionByte;
   logic [1:0] pinSync;
   logic oscLevel;
   logic oscLevelPrev;
   logic oscTick;
   logic monitorRequestSync;
   logic stopRequestOk;
   logic stopRequestBad;
   logic exitEvent;
   logic startRecovery;
   logic [12:0] recoveryLength;
   logic useShortRecovery;
   logic recoveryBusy;
   logic recoveryFinish;
   logic monitorAllowedNow;
   logic [17:0] next_watchdogTimeout;

   // ---------------------------------------------------------------
   // wishbone decode
   // ---------------------------------------------------------------
   assign busRequest = wb_cyc_i && wb_stb_i && !wb_ack_o;
   assign optionHit = (wb_adr_i == wor_pkg::OPTION_ADDR);
   assign statusHit = (wb_adr_i == wor_pkg::STATUS_ADDR);
   assign writeStrobe = busRequest && wb_we_i;
   // only the first write that reaches the option byte is taken
   assign optionWrite = writeStrobe && optionHit && wb_sel_i[0] && !locked;

   assign readMux = optionHit ? {24'h000000, optionByte} :
                    statusHit ? {24'h000000, statusByte} :
                    wor_pkg::UNMAPPED_READ;
   assign next_wbDat = (busRequest && !wb_we_i) ? readMux : wb_dat_o;

   // ---------------------------------------------------------------
   // register byte layout
   // ---------------------------------------------------------------
   // write data fields at their package positions
   always_comb begin
      writeOptions = wor_pkg::wor_options_type'(8'h00);
      writeOptions.slowCrystalSelect = wb_dat_i[wor_pkg::SLOW_CRYSTAL_BIT];
      writeOptions.voltMonitorInStop = wb_dat_i[wor_pkg::MON_IN_STOP_BIT];
      writeOptions.voltMonitorResetEnable = wb_dat_i[wor_pkg::MON_RESET_EN_BIT];
      writeOptions.voltMonitorPower = wb_dat_i[wor_pkg::MON_POWER_BIT];
      writeOptions.watchdogRateSelect = wb_dat_i[wor_pkg::WDOG_RATE_BIT];
      writeOptions.shortStopRecovery = wb_dat_i[wor_pkg::SHORT_RECOVERY_BIT];
      writeOptions.stopEnable = wb_dat_i[wor_pkg::STOP_ENABLE_BIT];
      writeOptions.watchdogDisable = wb_dat_i[wor_pkg::WDOG_DISABLE_BIT];
   end

   // read-back byte from the same positions
   always_comb begin
      optionByte = 8'h00;
      optionByte[wor_pkg::SLOW_CRYSTAL_BIT] = options.slowCrystalSelect;
      optionByte[wor_pkg::MON_IN_STOP_BIT] = options.voltMonitorInStop;
      optionByte[wor_pkg::MON_RESET_EN_BIT] = options.voltMonitorResetEnable;
      optionByte[wor_pkg::MON_POWER_BIT] = options.voltMonitorPower;
      optionByte[wor_pkg::WDOG_RATE_BIT] = options.watchdogRateSelect;
      optionByte[wor_pkg::SHORT_RECOVERY_BIT] = options.shortStopRecovery;
      optionByte[wor_pkg::STOP_ENABLE_BIT] = options.stopEnable;
      optionByte[wor_pkg::WDOG_DISABLE_BIT] = options.watchdogDisable;
   end

   // status bits at their package positions
   always_comb begin
      statusByte = 8'h00;
      statusByte[wor_pkg::STAT_LOCKED_BIT] = locked;
      statusByte[wor_pkg::STAT_RECOVERING_BIT] = recoveryBusy;
      statusByte[wor_pkg::STAT_STOPPED_BIT] = inStopMode;
   end

   // ---------------------------------------------------------------
   // option latch
   // ---------------------------------------------------------------
   assign next_options = optionWrite ? writeOptions : options;
   assign next_locked = locked || optionWrite;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         options <= wor_pkg::wor_options_type'(wor_pkg::OPTION_RESET);
         locked <= 1'b0;
      end else begin
         options <= next_options;
         locked <= next_locked;
      end
   end

   // ---------------------------------------------------------------
   // bus answer
   // ---------------------------------------------------------------
   // one registered ack per taken request; a request still held after its ack is answered again
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wb_ack_o <= 1'b0;
      end else begin
         wb_ack_o <= busRequest;
      end
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         wb_dat_o <= 32'h0000_0000;
      end else begin
         wb_dat_o <= next_wbDat;
      end
   end

   // ---------------------------------------------------------------
   // pin synchronisers
   // ---------------------------------------------------------------
   wor_sync3 #(
      .WIDTH(2)
   ) pinSyncInst (
      .clk(clk),
      .sys_rst(sys_rst),
      .asyncIn({voltMonitorResetRequest, oscillatorClock}),
      .syncOut(pinSync)
   );

   assign oscLevel = pinSync[0];
   assign monitorRequestSync = pinSync[1];

   // previous level resets low, matching the synchroniser output
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         oscLevelPrev <= 1'b0;
      end else begin
         oscLevelPrev <= oscLevel;
      end
   end

   // one pulse per oscillator rising edge
   assign oscTick = oscLevel && !oscLevelPrev;

   // ---------------------------------------------------------------
   // stop-mode sequencing
   // ---------------------------------------------------------------
   assign stopRequestOk = stopOpcodeFetch && options.stopEnable && (powerState == wor_pkg::PWR_RUN);
   assign stopRequestBad = stopOpcodeFetch && !options.stopEnable;
   assign exitEvent = (powerState == wor_pkg::PWR_STOPPED) && (stopWakeup || stopExitByReset);
   assign startRecovery = exitEvent;

   // reset exit ignores the short option
   assign useShortRecovery = options.shortStopRecovery && !stopExitByReset;
   assign recoveryLength = useShortRecovery ?
                           wor_pkg::SHORT_RECOVERY_CYCLES : wor_pkg::LONG_RECOVERY_CYCLES;

   wor_delay_counter #(
      .WIDTH(wor_pkg::RECOVERY_WIDTH)
   ) recoveryCounter (
      .clk(clk),
      .sys_rst(sys_rst),
      .start(startRecovery),
      .length(recoveryLength),
      .tick(oscTick),
      .busy(recoveryBusy),
      .done(recoveryFinish)
   );

   always_comb begin
      next_powerState = powerState;
      unique case (powerState)
         wor_pkg::PWR_RUN: begin
            if (stopRequestOk) begin
               next_powerState = wor_pkg::PWR_STOPPED;
            end
         end
         wor_pkg::PWR_STOPPED: begin
            if (exitEvent) begin
               next_powerState = wor_pkg::PWR_RECOVER;
            end
         end
         wor_pkg::PWR_RECOVER: begin
            if (recoveryFinish) begin
               next_powerState = wor_pkg::PWR_RUN;
            end
         end
         default: begin
            next_powerState = wor_pkg::PWR_RUN;
         end
      endcase
   end

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         powerState <= wor_pkg::PWR_RUN;
      end else begin
         powerState <= next_powerState;
      end
   end

   // registered strobes to the processor
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stopAccepted <= 1'b0;
         illegalOpcode <= 1'b0;
         recoveryDone <= 1'b0;
      end else begin
         stopAccepted <= stopRequestOk;
         illegalOpcode <= stopRequestBad;
         recoveryDone <= recoveryFinish;
      end
   end

   assign inStopMode = (powerState == wor_pkg::PWR_STOPPED);
   assign cpuHold = (powerState != wor_pkg::PWR_RUN);

   // ---------------------------------------------------------------
   // static controls
   // ---------------------------------------------------------------
   assign clockSlowCrystal = options.slowCrystalSelect;
   assign clockMonitorExpectLow = options.slowCrystalSelect;
   assign watchdogEnable = !options.watchdogDisable;

   // monitor stays powered in stop only when both bits are set
   assign monitorAllowedNow = !inStopMode || options.voltMonitorInStop;
   assign voltMonitorPowerOn = options.voltMonitorPower && monitorAllowedNow;
   assign voltMonitorResetOut = monitorRequestSync && options.voltMonitorResetEnable;

   assign next_watchdogTimeout = options.watchdogRateSelect ?
                                 wor_pkg::WDOG_FAST_TIMEOUT : wor_pkg::WDOG_SLOW_TIMEOUT;

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         watchdogTimeout <= wor_pkg::WDOG_SLOW_TIMEOUT;
      end else begin
         watchdogTimeout <= next_watchdogTimeout;
      end
   end

endmodule : wor_option_register

// ==== wor_option_register_checker.sv ====
// wor_option_register_checker: port assertions for the write-once option register.
// Assumes one clock domain and the design's asynchronous active-high reset.
`timescale 1ns/10ps
module wor_option_register_checker (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic wb_cyc_i,
   input wire logic wb_stb_i,
   input wire logic wb_we_i,
   input wire logic [7:0] wb_adr_i,
   input wire logic [3:0] wb_sel_i,
   input wire logic wb_ack_o,
   input wire logic stopOpcodeFetch,
   input wire wor_pkg::wor_options_type options,
   input wire logic clockSlowCrystal,
   input wire logic clockMonitorExpectLow,
   input wire logic voltMonitorPowerOn,
   input wire logic voltMonitorResetOut,
   input wire logic watchdogEnable,
   input wire logic [17:0] watchdogTimeout,
   input wire logic stopAccepted,
   input wire logic illegalOpcode,
   input wire logic inStopMode,
   input wire logic cpuHold
);
   // set once the option byte has been written
   logic seenWrite;
   wire optWrite = wb_ack_o && wb_we_i && wb_adr_i == wor_pkg::OPTION_ADDR && wb_sel_i[0];
   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) seenWrite <= 1'b0;
      else if (optWrite) seenWrite <= 1'b1;
   end
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   property p_ack; wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o; endproperty
   a_ack: assert property (p_ack) else $error("ack not a single pulse one cycle after request");
   property p_lock; seenWrite |-> $stable(options); endproperty
   a_lock: assert property (p_lock) else $error("options changed after first write");
   property p_reset; $past(sys_rst) |-> options == wor_pkg::OPTION_RESET; endproperty
   a_reset: assert property (p_reset) else $error("options not at default after reset");
   property p_slow; clockSlowCrystal == options.slowCrystalSelect && clockMonitorExpectLow == clockSlowCrystal;
   endproperty
   a_slow: assert property (p_slow) else $error("crystal controls differ from option");
   property p_power;
      voltMonitorPowerOn == (options.voltMonitorPower && (!inStopMode || options.voltMonitorInStop));
   endproperty
   a_power: assert property (p_power) else $error("monitor power wrong");
   property p_rate; options.watchdogRateSelect |=> watchdogTimeout == wor_pkg::WDOG_FAST_TIMEOUT; endproperty
   a_rate: assert property (p_rate) else $error("watchdog timeout wrong");
   property p_wden; watchdogEnable != options.watchdogDisable; endproperty
   a_wden: assert property (p_wden) else $error("watchdog enable wrong");
   property p_ill; stopOpcodeFetch && !options.stopEnable |=> illegalOpcode && !stopAccepted && !inStopMode;
   endproperty
   a_ill: assert property (p_ill) else $error("disabled stop not flagged illegal");
   property p_acc; stopOpcodeFetch && options.stopEnable && !cpuHold |=> stopAccepted && inStopMode && cpuHold;
   endproperty
   a_acc: assert property (p_acc) else $error("enabled stop not taken");
   property p_monrst; voltMonitorResetOut |-> options.voltMonitorResetEnable; endproperty
   a_monrst: assert property (p_monrst) else $error("monitor reset passed while blocked");
   c_write: cover property (optWrite);
   c_stop: cover property (stopAccepted);
   c_ill: cover property (illegalOpcode);
endmodule : wor_option_register_checker

bind wor_option_register wor_option_register_checker chk (.clk(clk), .sys_rst(sys_rst), .wb_cyc_i(wb_cyc_i),
   .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i), .wb_ack_o(wb_ack_o),
   .stopOpcodeFetch(stopOpcodeFetch), .options(options), .clockSlowCrystal(clockSlowCrystal),
   .clockMonitorExpectLow(clockMonitorExpectLow), .voltMonitorPowerOn(voltMonitorPowerOn),
   .voltMonitorResetOut(voltMonitorResetOut), .watchdogEnable(watchdogEnable), .watchdogTimeout(watchdogTimeout),
   .stopAccepted(stopAccepted), .illegalOpcode(illegalOpcode), .inStopMode(inStopMode), .cpuHold(cpuHold));

// ==== wor_pkg.sv ====
// wor_pkg: constants and types for the write-once option register.
// Assumes a 25 MHz system clock and a classic Wishbone slave with 32-bit data.
package wor_pkg;

   // ---------------------------------------------------------------
   // register map
   // ---------------------------------------------------------------
   localparam logic [7:0] OPTION_INDEX = 8'h1F;
   localparam logic [7:0] STATUS_INDEX = 8'h20;
   localparam logic [7:0] OPTION_ADDR = {OPTION_INDEX[5:0], 2'b00};
   localparam logic [7:0] STATUS_ADDR = {STATUS_INDEX[5:0], 2'b00};
   localparam logic [31:0] UNMAPPED_READ = 32'h0000_0000;

   // ---------------------------------------------------------------
   // option field positions
   // ---------------------------------------------------------------
   localparam int SLOW_CRYSTAL_BIT = 7;
   localparam int MON_IN_STOP_BIT = 6;
   localparam int MON_RESET_EN_BIT = 5;
   localparam int MON_POWER_BIT = 4;
   localparam int WDOG_RATE_BIT = 3;
   localparam int SHORT_RECOVERY_BIT = 2;
   localparam int STOP_ENABLE_BIT = 1;
   localparam int WDOG_DISABLE_BIT = 0;

   // ---------------------------------------------------------------
   // status field positions
   // ---------------------------------------------------------------
   localparam int STAT_LOCKED_BIT = 0;
   localparam int STAT_RECOVERING_BIT = 1;
   localparam int STAT_STOPPED_BIT = 2;

   // ---------------------------------------------------------------
   // reset value and timing counts in oscillator cycles
   // ---------------------------------------------------------------
   localparam logic [7:0] OPTION_RESET = 8'h30;
   localparam int RECOVERY_WIDTH = 13;
   localparam logic [12:0] SHORT_RECOVERY_CYCLES = 13'h0020;
   localparam logic [12:0] LONG_RECOVERY_CYCLES = 13'h1000;
   localparam logic [17:0] WDOG_FAST_TIMEOUT = 18'h01FF0;
   localparam logic [17:0] WDOG_SLOW_TIMEOUT = 18'h3FFF0;

   // ---------------------------------------------------------------
   // types
   // ---------------------------------------------------------------
   typedef struct packed {
      logic slowCrystalSelect;
      logic voltMonitorInStop;
      logic voltMonitorResetEnable;
      logic voltMonitorPower;
      logic watchdogRateSelect;
      logic shortStopRecovery;
      logic stopEnable;
      logic watchdogDisable;
   } wor_options_type;

   typedef enum logic [2:0] {
      PWR_RUN = 3'b001,
      PWR_STOPPED = 3'b010,
      PWR_RECOVER = 3'b100
   } wor_power_state_type;

endpackage : wor_pkg

// ==== wor_sync3.sv ====
// wor_sync3: three-stage input synchroniser with agreement filter.
// Assumes the input is asynchronous to clk.
`timescale 1ns/10ps
module wor_sync3 #(
   parameter int WIDTH = 1
) (
   input wire logic clk,
   input wire logic sys_rst,
   input wire logic [WIDTH-1:0] asyncIn,
   output logic [WIDTH-1:0] syncOut
);
   logic [WIDTH-1:0] stage1;
   logic [WIDTH-1:0] stage2;
   logic [WIDTH-1:0] stage3;
   logic [WIDTH-1:0] next_syncOut;

   // a bit changes only once stages two and three agree
   assign next_syncOut = (stage2 & stage3) | (syncOut & (stage2 ^ stage3));

   always_ff @(posedge clk or posedge sys_rst) begin
      if (sys_rst) begin
         stage1 <= '0;
         stage2 <= '0;
         stage3 <= '0;
         syncOut <= '0;
      end else begin
         stage1 <= asyncIn;
         stage2 <= stage1;
         stage3 <= stage2;
         syncOut <= next_syncOut;
      end
   end
endmodule : wor_sync3

// ==== write_once_option_register_bench.sv ====
// write_once_option_register_bench: bus and stop-mode scenarios for the option register.
// Assumes the checker is bound from its own file.
`timescale 1ns/10ps
module write_once_option_register_bench;
   logic clk = 0, sysRst = 1, cyc = 0, stb = 0, we = 0, osc = 0, monReq = 0, fetch = 0, wake = 0, rstExit = 0;
   logic [7:0] adr = 0;
   logic [3:0] sel = 0;
   logic [31:0] wdat = 0, rdat, rd;
   logic ack, slowX, expLow, pwrOn, monOut, wdEn, acc, ill, inStop, hold, recDone, accSeen, illSeen, pwrStop;
   logic holdSeen;
   logic [17:0] wdTime;
   wor_pkg::wor_options_type opts;
   int nFail = 0, testsRun = 0, n, c, oscDiv = 0;
   localparam logic [7:0] OA = wor_pkg::OPTION_ADDR;
   always #20 clk = ~clk;
   // free-running external clock source, not a crystal; one rising edge every 8 clocks
   always @(posedge clk) begin
      oscDiv <= (oscDiv + 1) % 4;
      if (oscDiv == 3) osc <= ~osc;
   end
   wor_option_register uut (.clk(clk), .sys_rst(sysRst), .wb_cyc_i(cyc), .wb_stb_i(stb), .wb_we_i(we),
      .wb_adr_i(adr), .wb_sel_i(sel), .wb_dat_i(wdat), .wb_dat_o(rdat), .wb_ack_o(ack), .oscillatorClock(osc),
      .voltMonitorResetRequest(monReq), .stopOpcodeFetch(fetch), .stopWakeup(wake), .stopExitByReset(rstExit),
      .options(opts), .clockSlowCrystal(slowX), .clockMonitorExpectLow(expLow), .voltMonitorPowerOn(pwrOn),
      .voltMonitorResetOut(monOut), .watchdogEnable(wdEn), .watchdogTimeout(wdTime), .stopAccepted(acc),
      .illegalOpcode(ill), .inStopMode(inStop), .cpuHold(hold), .recoveryDone(recDone));
   task automatic finish_test;
      $display("comparisons %0d mismatches %0d", testsRun, nFail);
      if (nFail == 0 && testsRun > 0)
         $display("STATUS OK");
      else
         $display("STATUS NOT OK");
      $finish;
   endtask : finish_test
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      testsRun++;
      if (seen !== exp) begin
         nFail++;
         $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   function automatic logic [31:0] near(input int cnt, input int target);
      return {31'h0, cnt >= target - 8 && cnt <= target + 32};
   endfunction : near
   task automatic reset_dut;
      sysRst <= 1'b1;
      repeat (4) @(posedge clk);
      sysRst <= 1'b0;
      @(posedge clk);
   endtask : reset_dut
   task automatic wb(input logic w, input logic [7:0] a, input logic [3:0] s, input logic [31:0] d);
      n = 0;
      cyc <= 1'b1;
      stb <= 1'b1;
      we <= w;
      adr <= a;
      sel <= s;
      wdat <= d;
      do begin
         @(posedge clk);
         n++;
      end while (ack !== 1'b1 && n < 20);
      rd = rdat;
      cyc <= 1'b0;
      stb <= 1'b0;
      we <= 1'b0;
      if (n >= 20) begin
         nFail++;
         finish_test();
      end
      @(posedge clk);
   endtask : wb
   // stop opcode, then wake by interrupt or by reset pin; c counts clocks to recoveryDone
   task automatic stop_seq(input logic byReset);
      fetch <= 1'b1;
      @(posedge clk);
      fetch <= 1'b0;
      @(posedge clk);
      accSeen = acc;
      illSeen = ill;
      pwrStop = pwrOn;
      holdSeen = hold;
      c = 0;
      if (inStop === 1'b1) begin
         wake <= !byReset;
         rstExit <= byReset;
         @(posedge clk);
         wake <= 1'b0;
         rstExit <= 1'b0;
         do begin
            @(posedge clk);
            c++;
         end while (recDone !== 1'b1 && c < 40000);
         if (c >= 40000) begin
            nFail++;
            finish_test();
         end
      end
   endtask : stop_seq
   initial begin
      reset_dut();
      wb(0, OA, 4'hF, 0);
      check(rd, 32'h30);
      check(32'(wdTime), 32'h3FFF0);
      wb(1, OA, 4'hE, 32'hDE);
      wb(0, OA, 4'hF, 0);
      check(rd, 32'h30);
      wb(1, OA, 4'hF, 32'hDE);
      wb(0, OA, 4'hF, 0);
      check(rd, 32'hDE);
      check(32'(opts), 32'hDE);
      check({slowX, expLow, wdEn}, 32'h7);
      check(32'(wdTime), 32'h01FF0);
      wb(1, OA, 4'hF, 32'h21);
      wb(0, OA, 4'hF, 0);
      check(rd, 32'hDE);
      wb(0, wor_pkg::STATUS_ADDR, 4'hF, 0);
      check(rd & 32'h1, 32'h1);
      wb(0, 8'hFC, 4'hF, 0);
      check(rd, 32'h0);
      monReq <= 1'b1;
      repeat (8) @(posedge clk);
      check(32'(monOut), 32'h0);
      stop_seq(0);
      check({accSeen, pwrStop}, 32'h3);
      check(near(c, 32 * 8), 32'h1);
      check({holdSeen, hold, inStop}, 32'h4);
      reset_dut();
      repeat (8) @(posedge clk);
      check(32'(monOut), 32'h1);
      wb(1, OA, 4'hF, 32'h04);
      check(32'(pwrOn), 32'h0);
      stop_seq(0);
      check({accSeen, illSeen}, 32'h1);
      reset_dut();
      wb(1, OA, 4'hF, 32'h37);
      check({wdEn, pwrOn}, 32'h1);
      stop_seq(1);
      check({accSeen, pwrStop}, 32'h2);
      check(near(c, 4096 * 8), 32'h1);
      finish_test();
   end
endmodule : write_once_option_register_bench
